// ===== design/oadc_pkg.sv
// Constants shared by the octal converter digital input/output block.
package oadc_pkg;

   // Converter geometry.
   localparam int NUM_CH      = 8;        // Number of converter channels.
   localparam int WORD_W      = 10;       // Bits per sample word.
   localparam int DEF_LATENCY = 5;        // Default pipeline latency in sample cycles.

   // Timing of the sample clock and the standby recovery.
   localparam int CLK_PERIOD_NS   = 25;   // Sample clock period at 40 MHz.
   localparam int RECOVERY_CYCLES = 7;    // Sample cycles before data is valid again.
   localparam int RECOVERY_W      = 3;    // Width of the recovery counter.

   // Offset binary landmarks of the output code.
   localparam logic [WORD_W-1:0] CODE_NEG_FS   = 10'h000;  // Negative full scale.
   localparam logic [WORD_W-1:0] CODE_NEG_HALF = 10'h100;  // Minus half scale.
   localparam logic [WORD_W-1:0] CODE_ZERO     = 10'h200;  // Zero differential input.
   localparam logic [WORD_W-1:0] CODE_POS_HALF = 10'h300;  // Plus half scale.
   localparam logic [WORD_W-1:0] CODE_POS_FS   = 10'h3ff;  // Full scale minus one step.

   // Register map, byte addresses of aligned 32-bit words.
   localparam logic [7:0] REG_CHAN_ENABLE = 8'h00;  // Software channel enable mask.
   localparam logic [7:0] REG_STATUS      = 8'h04;  // Channel ready mask and modes.
   localparam logic [7:0] REG_SAMPLE_SEL  = 8'h08;  // Channel picked for sample readback.
   localparam logic [7:0] REG_SAMPLE      = 8'h0c;  // Last word of the picked channel.

   // Field positions inside the status register.
   localparam int STAT_READY_LSB = 0;     // Ready mask, one bit per channel.
   localparam int STAT_COND_BIT  = 8;     // Clock conditioning active.
   localparam int STAT_DRIVE_BIT = 9;     // Data buses driven.

   // Values after reset.
   localparam logic [NUM_CH-1:0] RST_CHAN_ENABLE = 8'hff;  // All channels allowed.
   localparam logic [2:0]        RST_SAMPLE_SEL  = 3'h0;   // Channel zero picked.

endpackage

// ===== design/oadc_digital_io.sv
// Digital side of the eight-channel converter: coding, pipeline, standby, buses and registers.
`timescale 1ns/100ps

// Contract
// RULE1: Select low bypasses the clock conditioning.
// RULE2: Select high enables the clock conditioning.
// RULE3: Pipeline uses both sample clock edges; the code folds each edge pair into one rising-edge stage.
// RULE4: Sample clock stays at or above 1MSPS.
// RULE5: Words are 10-bit positive offset binary.
// RULE6: Zero gives 0x200, half scales 0x300/0x100.
// RULE7: Word MSB appears on bit nine line.
// RULE8: Enable low drives all channel buses.
// RULE9: Enable high floats all eight buses together.
// RULE10: Controller always drives the output enable.
// RULE11: Per-channel standby, low powers channel down.
// RULE12: Entering standby invalidates in-flight samples.
// RULE13: Outputs invalid for seven cycles after standby.
// RULE14: Standby not used for dynamic channel multiplexing.
// RULE15: Sample clock present during power-up.
// RULE16: One word per cycle after fixed latency.
module oadc_digital_io
#(
   parameter int LATENCY = oadc_pkg::DEF_LATENCY   // Pipeline depth in sample cycles.
)
(
   input  wire logic                                          clk_sys_i,
   input  wire logic                                          rst_b_i,
   // Pin controls.
   input  wire logic                                          duty_adjust_select_i,
   input  wire logic                                          oe_b_i,
   input  wire logic [oadc_pkg::NUM_CH-1:0]                   channel_standby_low_i,
   // Quantised front-end samples, two's complement per channel.
   input  wire logic [oadc_pkg::NUM_CH*oadc_pkg::WORD_W-1:0]  sample_i,
   input  wire logic                                          sample_valid_i,
   output logic                                               sample_ready_o,
   // Parallel output words toward the capture logic.
   output logic [oadc_pkg::NUM_CH*oadc_pkg::WORD_W-1:0]       adc_word_o,
   output logic [oadc_pkg::NUM_CH-1:0]                        adc_word_vld_o,
   output logic                                               adc_valid_o,
   input  wire logic                                          adc_ready_i,
   output logic [oadc_pkg::NUM_CH-1:0]                        msb_output_line_o,
   output logic                                               adc_word_oe_b_o,
   output logic                                               clk_cond_en_o,
   // APB slave.
   input  wire logic                                          psel,
   input  wire logic                                          penable,
   input  wire logic                                          pwrite,
   input  wire logic [7:0]                                    paddr,
   input  wire logic [31:0]                                   pwdata,
   output logic [31:0]                                        prdata,
   output logic                                               pready,
   output logic                                               pslverr
);
   import oadc_pkg::*;

   localparam int BUS_W = NUM_CH * WORD_W;   // Width of all channel words together.
   localparam int ENT_W = BUS_W + NUM_CH;    // Buffer entry: words plus valid mask.

   // Converts a two's complement sample into positive offset binary.
   function automatic logic [WORD_W-1:0] offset_binary_code(input logic [WORD_W-1:0] s);
      offset_binary_code = {~s[WORD_W-1], s[WORD_W-2:0]};
   endfunction

   // Register state.
   logic [NUM_CH-1:0]              chan_enable;    // Software mask, 1 lets a channel run.
   logic [2:0]                     sample_sel;     // Channel shown in the sample register.
   // Channel state.
   logic [NUM_CH-1:0]              chan_ready;     // Channel past its recovery time.
   logic [NUM_CH-1:0][RECOVERY_W-1:0] rec_cnt;     // Recovery counters.
   logic [LATENCY-1:0][BUS_W-1:0]  pipe_data;      // Pipeline words per stage.
   logic [LATENCY-1:0][NUM_CH-1:0] pipe_vld;       // Pipeline validity per stage.
   // Two-entry output buffer: head register and skid register.
   logic [ENT_W-1:0]               head_ent;       // Entry presented to the capture logic.
   logic                           head_full;      // Head register holds an entry.
   logic [ENT_W-1:0]               skid_ent;       // Second entry caught during a stall.
   logic                           skid_full;      // Skid register holds an entry.
   logic                           cond_en;        // Registered conditioning mode.
   logic                           drive_b;        // Registered bus drive, low drives.

   // Decoding and selection.
   wire logic [NUM_CH-1:0] channel_standby_low_eff   = channel_standby_low_i & chan_enable;
   wire logic              buf_ready  = ~skid_full;
   wire logic              advance    = buf_ready;
   wire logic [ENT_W-1:0]  tail_ent   = {pipe_vld[LATENCY-1], pipe_data[LATENCY-1]};
   wire logic              push       = advance & (|pipe_vld[LATENCY-1]);
   wire logic              pop        = head_full & adc_ready_i;
   wire logic              apb_access = psel & penable;
   wire logic              apb_wr     = apb_access & pwrite;
   wire logic              addr_hit   = (paddr == REG_CHAN_ENABLE) | (paddr == REG_STATUS) |
                                        (paddr == REG_SAMPLE_SEL)  | (paddr == REG_SAMPLE);
   wire logic [BUS_W-1:0]  sel_shift  = head_ent[BUS_W-1:0] >> (sample_sel * WORD_W);
   wire logic [WORD_W-1:0] sel_word   = sel_shift[WORD_W-1:0];

   // The sample source is stalled by the same term that stalls the pipeline.
   assign sample_ready_o = buf_ready;

   // Duty-cycle mode: the conditioning enable follows the select pin, one cycle late.
   always_ff @(posedge clk_sys_i or negedge rst_b_i)
   begin
      if (!rst_b_i)
      begin
         cond_en <= 1'b0;
      end
      else
      begin
         // RULE1 RULE2 conditioning mode select
         cond_en <= duty_adjust_select_i;
      end
   end

   assign clk_cond_en_o = cond_en;

   // Output enable: one shared level floats or drives every channel bus at once.
   // Registered so the enable change lines up with the data register edge.
   always_ff @(posedge clk_sys_i or negedge rst_b_i)
   begin
      if (!rst_b_i)
      begin
         drive_b <= 1'b1;   // Buses float until the enable is seen low.
      end
      else
      begin
         // RULE8 RULE9 shared bus enable
         drive_b <= oe_b_i;
      end
   end

   assign adc_word_oe_b_o = drive_b;

   // Standby recovery: a channel is ready only after seven whole cycles out of standby.
   always_ff @(posedge clk_sys_i or negedge rst_b_i)
   begin
      if (!rst_b_i)
      begin
         chan_ready <= '0;
         rec_cnt    <= '0;
      end
      else
      begin
         for (int c = 0; c < NUM_CH; c++)
         begin
            // RULE11 RULE13 standby and recovery
            if (!channel_standby_low_eff[c])
            begin
               // Powered down: restart the recovery window.
               chan_ready[c] <= 1'b0;
               rec_cnt[c]    <= '0;
            end
            else if (!chan_ready[c])
            begin
               // Counting the recovery cycles.
               rec_cnt[c] <= rec_cnt[c] + RECOVERY_W'(1);
               if (rec_cnt[c] == RECOVERY_W'(RECOVERY_CYCLES - 1))
               begin
                  chan_ready[c] <= 1'b1;
               end
            end
         end
      end
   end

   // Conversion pipeline. Each stage stands for a rising-edge step and the falling-edge
   // step after it, folded into one system clock cycle; a stall holds every stage.
   always_ff @(posedge clk_sys_i or negedge rst_b_i)
   begin
      if (!rst_b_i)
      begin
         pipe_data <= '0;
         pipe_vld  <= '0;
      end
      else
      begin
         if (advance)
         begin
            // RULE3 RULE16 one word per cycle
            for (int c = 0; c < NUM_CH; c++)
            begin
               // RULE5 RULE6 offset binary coding
               pipe_data[0][c*WORD_W +: WORD_W] <= offset_binary_code(sample_i[c*WORD_W +: WORD_W]);
               pipe_vld[0][c] <= sample_valid_i & chan_ready[c] & channel_standby_low_eff[c];
            end
            for (int s = 1; s < LATENCY; s++)
            begin
               pipe_data[s] <= pipe_data[s-1];
               pipe_vld[s]  <= pipe_vld[s-1] & channel_standby_low_eff;
            end
         end
         else
         begin
            // Held stages still lose their samples if the channel drops to standby.
            for (int s = 0; s < LATENCY; s++)
            begin
               pipe_vld[s] <= pipe_vld[s] & channel_standby_low_eff;
            end
         end
         // RULE12 standby flushes samples
         if (!advance)
         begin
            pipe_vld[0] <= pipe_vld[0] & channel_standby_low_eff;
         end
      end
   end

   // Two-entry output buffer. The head register drives the pins; the skid register
   // catches the word that was already on its way when the capture logic stalled.
   always_ff @(posedge clk_sys_i or negedge rst_b_i)
   begin
      if (!rst_b_i)
      begin
         head_ent  <= '0;
         head_full <= 1'b0;
         skid_ent  <= '0;
         skid_full <= 1'b0;
      end
      else
      begin
         if (!head_full || pop)
         begin
            // Head is free this cycle: refill from skid first, else from the pipeline.
            if (skid_full)
            begin
               head_ent  <= skid_ent;
               head_full <= 1'b1;
               skid_full <= 1'b0;
            end
            else
            begin
               head_ent  <= push ? tail_ent : head_ent;
               head_full <= push;
            end
         end
         else if (push)
         begin
            // Head is stalled: park the arriving word.
            skid_ent  <= tail_ent;
            skid_full <= 1'b1;
         end
      end
   end

   // RULE7 MSB on bit nine
   always_comb
   begin
      for (int c = 0; c < NUM_CH; c++)
      begin
         msb_output_line_o[c] = head_ent[c*WORD_W + WORD_W - 1];
      end
   end

   assign adc_word_o     = head_ent[BUS_W-1:0];
   assign adc_word_vld_o = head_ent[ENT_W-1:BUS_W];
   assign adc_valid_o    = head_full;

   // APB register writes.
   always_ff @(posedge clk_sys_i or negedge rst_b_i)
   begin
      if (!rst_b_i)
      begin
         chan_enable <= RST_CHAN_ENABLE;
         sample_sel  <= RST_SAMPLE_SEL;
      end
      else if (apb_wr)
      begin
         if (paddr == REG_CHAN_ENABLE)
         begin
            chan_enable <= pwdata[NUM_CH-1:0];
         end
         else if (paddr == REG_SAMPLE_SEL)
         begin
            sample_sel <= pwdata[2:0];
         end
      end
   end

   // APB read mux; the slave answers with no wait states.
   always_comb
   begin
      prdata = 32'h0000_0000;
      if (apb_access && !pwrite)
      begin
         case (paddr)
            REG_CHAN_ENABLE: prdata[NUM_CH-1:0] = chan_enable;
            REG_STATUS:
            begin
               prdata[STAT_READY_LSB +: NUM_CH] = chan_ready;
               prdata[STAT_COND_BIT]            = cond_en;
               prdata[STAT_DRIVE_BIT]           = ~drive_b;
            end
            REG_SAMPLE_SEL:  prdata[2:0] = sample_sel;
            REG_SAMPLE:      prdata[WORD_W-1:0] = sel_word;
            default:         prdata = 32'h0000_0000;
         endcase
      end
   end

   assign pready  = 1'b1;
   assign pslverr = apb_access & ~addr_hit;

   // Checks.
   default clocking cb @(posedge clk_sys_i); endclocking
   default disable iff (!rst_b_i);

   chk_cond_bypass: assert property (!duty_adjust_select_i |=> !clk_cond_en_o) // RULE1
      else $error("Conditioning not bypassed after select low.");
   chk_cond_active: assert property (duty_adjust_select_i |=> clk_cond_en_o) // RULE2
      else $error("Conditioning not enabled after select high.");
   chk_offset_code: assert property (advance |=> pipe_data[0][9] == ~$past(sample_i[9]) && pipe_data[0][8:0] == $past(sample_i[8:0])) // RULE5
      else $error("Stage zero word is not offset binary.");
   chk_zero_code: assert property (advance && sample_i[9:0] == 10'h000 |=> pipe_data[0][9:0] == CODE_ZERO) // RULE6
      else $error("Zero input did not give the mid code.");
   chk_bus_drive: assert property (!oe_b_i |=> !adc_word_oe_b_o) // RULE8
      else $error("Buses not driven with enable low.");
   chk_bus_float: assert property (oe_b_i |=> adc_word_oe_b_o) // RULE9
      else $error("Buses not floated with enable high.");
   chk_channel_standby_low_flush: assert property (!channel_standby_low_eff[0] |=> pipe_vld[LATENCY-1][0] == 1'b0 && !chan_ready[0]) // RULE12
      else $error("Channel zero kept samples through standby.");
   chk_recovery_hold: assert property ($rose(channel_standby_low_eff[0]) |-> !chan_ready[0] [*7]) // RULE13
      else $error("Channel zero ready before seven cycles.");
   chk_recovery_done: assert property ($rose(channel_standby_low_eff[0]) ##0 channel_standby_low_eff[0] [*8] |-> chan_ready[0]) // RULE13
      else $error("Channel zero not ready after recovery.");
   chk_stall_hold: assert property (adc_valid_o && !adc_ready_i |=> adc_valid_o && $stable(adc_word_o)) // RULE16
      else $error("Stalled output word changed or dropped.");
   chk_msb_line: assert property (adc_valid_o |-> msb_output_line_o[0] == adc_word_o[WORD_W-1]) // RULE7
      else $error("MSB line does not carry bit nine.");

endmodule

// ===== tb/oadc_capture_model.sv
// Capture logic model that latches the parallel sample words leaving the converter.
`timescale 1ns/100ps
module oadc_capture_model
(
   input  wire logic                                          clk_sys_i,
   input  wire logic                                          rst_b_i,
   input  wire logic                                          hold_i,
   input  wire logic [oadc_pkg::NUM_CH*oadc_pkg::WORD_W-1:0]  adc_word_i,
   input  wire logic [oadc_pkg::NUM_CH-1:0]                   adc_word_vld_i,
   input  wire logic [oadc_pkg::NUM_CH-1:0]                   msb_output_line_i,
   input  wire logic                                          adc_valid_i,
   output logic                                               adc_ready_o
);
   import oadc_pkg::*;

   logic [1:0]  phase;     // Slow pattern counter, refuses one cycle in three.
   logic [95:0] got_q[$];  // Latched entries: msb lines, validity, then the words.

   // Ready drops for a whole stall and also every third cycle, so the block meets a slow taker.
   always @(posedge clk_sys_i or negedge rst_b_i)
   begin
      if (!rst_b_i)
      begin
         phase       <= 2'h0;
         adc_ready_o <= 1'b0;
      end
      else
      begin
         phase       <= (phase == 2'h2) ? 2'h0 : phase + 2'h1;
         adc_ready_o <= !hold_i && (phase != 2'h2);
      end
   end

   // An entry is latched only at an edge where both sides agree.
   always @(posedge clk_sys_i)
   begin
      if (rst_b_i && adc_valid_i && adc_ready_o)
         got_q.push_back({msb_output_line_i, adc_word_vld_i, adc_word_i});
   end
endmodule

// ===== tb/octal_adc_digital_io_tb_top.sv
// Self-checking testbench of the octal converter digital input/output block.
`timescale 1ns/100ps
module octal_adc_digital_io_tb_top;
   import oadc_pkg::*;

   logic        clk = 1'b0;                  // Sample clock.
   logic        rst_b = 1'b0;                // Active-low reset.
   logic        duty = 1'b0;                 // Conditioning select.
   logic        oe_b = 1'b0;                 // Shared output enable.
   logic [7:0]  channel_standby_low_b = 8'hff;              // Per-channel standby, active low.
   logic [79:0] smp = '0;                    // Front-end samples.
   logic        smp_vld = 1'b0;              // Samples valid.
   logic        smp_rdy, adc_vld, adc_rdy, oe_b_q, cond, psel = 0, penable = 0, pwrite = 0;
   logic        pready, pslverr, hold = 1'b0;
   logic [79:0] words;
   logic [7:0]  vld, msb, paddr = 8'h00;
   logic [31:0] pwdata = '0, prdata, q;
   logic        e;
   int          mismatches = 0;
   int          checked = 0;
   int          refused = 0;
   logic [9:0]  lm[5] = '{CODE_NEG_FS, CODE_NEG_HALF, CODE_ZERO, CODE_POS_HALF, CODE_POS_FS};

   always #12.5 clk = ~clk;

   oadc_digital_io #(.LATENCY(5)) u_dut (.clk_sys_i(clk), .rst_b_i(rst_b),
      .duty_adjust_select_i(duty), .oe_b_i(oe_b), .channel_standby_low_i(channel_standby_low_b),
      .sample_i(smp), .sample_valid_i(smp_vld), .sample_ready_o(smp_rdy), .adc_word_o(words),
      .adc_word_vld_o(vld), .adc_valid_o(adc_vld), .adc_ready_i(adc_rdy),
      .msb_output_line_o(msb), .adc_word_oe_b_o(oe_b_q), .clk_cond_en_o(cond), .psel(psel),
      .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
      .pready(pready), .pslverr(pslverr));

   oadc_capture_model u_cap (.clk_sys_i(clk), .rst_b_i(rst_b), .hold_i(hold),
      .adc_word_i(words), .adc_word_vld_i(vld), .msb_output_line_i(msb),
      .adc_valid_i(adc_vld), .adc_ready_o(adc_rdy));

   // One comparison, counted, reported at once when it differs.
   task automatic chk(input string name, input logic [31:0] got, input logic [31:0] exp);
      checked++;
      if (got !== exp)
      begin
         mismatches++;
         $display("ERROR %s expected %h seen %h", name, exp, got);
      end
   endtask

   // One APB transfer; a free cycle follows so the next setup never collides.
   task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] d);
      int n;
      psel <= 1'b1; penable <= 1'b0; pwrite <= wr; paddr <= a; pwdata <= d;
      @(posedge clk);
      penable <= 1'b1;
      n = 0;
      do begin @(posedge clk); n++; end while (pready !== 1'b1 && n < 100);
      q = prdata;
      e = pslverr;
      psel <= 1'b0; penable <= 1'b0;
      @(posedge clk);
   endtask

   // Back-to-back sample sets; channel c of set k carries landmark (k+c) mod 5.
   task automatic burst(input int k0, input int n);
      int w;
      for (int k = k0; k < k0 + n; k++)
      begin
         for (int c = 0; c < NUM_CH; c++) smp[c*WORD_W +: WORD_W] <= lm[(k+c)%5] ^ 10'h200;
         smp_vld <= 1'b1;
         w = 0;
         do begin @(posedge clk); w++; if (smp_rdy !== 1'b1) refused++; end
         while (smp_rdy !== 1'b1 && w < 200);
      end
      smp_vld <= 1'b0;
   endtask

   // Waits for n entries at the taker and compares words, validity and msb lines.
   task automatic expect_words(input int k0, input int n, input logic [7:0] m);
      int w;
      logic [95:0] g;
      w = 0;
      while (u_cap.got_q.size() < n && w < 300) begin @(posedge clk); w++; end
      chk("entries", u_cap.got_q.size(), n);
      for (int k = k0; k < k0 + n && u_cap.got_q.size() > 0; k++)
      begin
         g = u_cap.got_q.pop_front();
         chk("validity", g[87:80], m);
         for (int c = 0; c < NUM_CH; c++)
            if (m[c])
            begin
               chk("word", g[c*10 +: 10], lm[(k+c)%5]);
               chk("msb line", g[88+c], lm[(k+c)%5][9]);
            end
      end
   endtask

   // Reset values, unmapped refusal, software channel enable.
   task automatic test_regs();
      apb(1'b0, REG_CHAN_ENABLE, '0); chk("chan enable", q, 32'h0000_00ff);
      apb(1'b0, REG_SAMPLE_SEL, '0);  chk("sample sel", q, 32'h0000_0000);
      apb(1'b0, REG_STATUS, '0);      chk("status", q, 32'h0000_02ff);
      apb(1'b0, 8'h10, '0);           chk("unmapped err", e, 1'b1);
      apb(1'b1, REG_SAMPLE_SEL, 32'h5); apb(1'b0, REG_SAMPLE_SEL, '0); chk("sel rb", q, 32'h5);
      apb(1'b1, REG_CHAN_ENABLE, 32'hfe);
      apb(1'b0, REG_STATUS, '0);      chk("status masked", q, 32'h0000_02fe);
      apb(1'b1, REG_CHAN_ENABLE, 32'hff);
      repeat (10) @(posedge clk);
   endtask

   // Forty-cycle full stall, long enough for the input to refuse, then drain at a slow pace.
   task automatic test_stream();
      hold <= 1'b1;
      fork
         burst(0, 12);
         begin repeat (40) @(posedge clk); hold <= 1'b0; end
      join
      chk("refused", refused > 0, 1'b1);
      expect_words(0, 12, 8'hff);
      // The head register keeps the last word; channel five is still picked.
      apb(1'b0, REG_SAMPLE, '0); chk("sample rb", q, {22'h0, lm[(11+5)%5]});
   endtask

   task automatic test_standby();
      channel_standby_low_b <= 8'hf7;
      repeat (3) @(posedge clk);
      burst(3, 1);
      expect_words(3, 1, 8'hf7);
      channel_standby_low_b <= 8'hff;
      @(posedge clk);
      apb(1'b0, REG_STATUS, '0); chk("ready early", q, 32'h0000_02f7);
      repeat (10) @(posedge clk);
      apb(1'b0, REG_STATUS, '0); chk("ready late", q, 32'h0000_02ff);
   endtask

   // Output enable floats the buses, select turns conditioning on.
   task automatic test_modes();
      oe_b <= 1'b1;
      duty <= 1'b1;
      repeat (2) @(posedge clk);
      chk("oe out", oe_b_q, 1'b1);
      chk("cond", cond, 1'b1);
      apb(1'b0, REG_STATUS, '0); chk("status modes", q, 32'h0000_01ff);
      oe_b <= 1'b0;
      duty <= 1'b0;
      repeat (2) @(posedge clk);
      chk("oe back", oe_b_q, 1'b0);
      chk("bypass", cond, 1'b0);
   endtask

   task automatic summarize();
      if (mismatches == 0 && checked > 0)
         $display("Result: passed");
      else
         $display("Result: failed");
      $finish;
   endtask

   initial
   begin
      repeat (6) @(posedge clk);
      rst_b <= 1'b1;
      repeat (10) @(posedge clk);
      test_regs();
      test_stream();
      test_standby();
      test_modes();
      summarize();
   end

   // Watchdog far beyond the few hundred cycles the tests need.
   initial
   begin
      #(CLK_PERIOD_NS * 5000);
      mismatches++;
      summarize();
   end
endmodule
